//--- src/pph_parallel_port.sv
// Notes on behaviour
// - Strobe low loads input; rising edge requests interrupt
// - After strobe, ready drops; register full, loads inhibited
// - Ready returns after the read strobe ends
// - Ready already high forced low during read
// - Bidirectional only on port A; B bit control
// - B bit interrupt and A bidir input share vector
// - Bidir: A lines output, B lines input; drive when A strobe low
// - Bidir input latched on B strobe low level
// - Bit control: no handshake, writes latch anytime
// - Bit control holds ready low; B spared under bidir
// - Bit control read mixes output and sampled input bits
// - Equation interrupt only on false-to-true change
// - Equation true near fetch strobe defers request
// - Request status frozen while fetch strobe active
// - Acknowledge: enable-in high, enable-out low port sends vector
// - Serviced port holds enable-out low until return decoded
// - Pending port lets enable-out high after prefix byte
// - At most four chained devices without look-ahead
// - Mode word: bits 7:6 mode, bits 3:0 all ones
// - Control word bit 6 AND/OR, bit 5 level
// - Only unmasked lines join the equation
`timescale 1ns/1ps
module pph_parallel_port (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic chip_sel_n_i,
    input wire logic port_sel_i,
    input wire logic ctrl_sel_i,
    input wire logic rd_n_i,
    input wire logic io_request_strobe_n_i,
    input wire logic opcode_fetch_strobe_n_i,
    input wire logic [7:0] cpu_data_i,
    output logic [7:0] cpu_data_o,
    output logic cpu_data_oe_o,
    output logic int_n_o,
    input wire logic priority_enable_in_i,
    output logic priority_enable_out_o,
    input wire logic cfg_wr_i,
    input wire logic cfg_port_i,
    input wire pph_pkg::pph_cfg_e cfg_kind_i,
    input wire logic [7:0] cfg_word_i,
    input wire logic [7:0] vector_a_i,
    input wire logic [7:0] vector_b_i,
    input wire logic [7:0] port_a_data_i,
    output logic [7:0] port_a_data_o,
    output logic [7:0] port_a_data_oe_o,
    input wire logic [7:0] port_b_data_i,
    output logic [7:0] port_b_data_o,
    output logic [7:0] port_b_data_oe_o,
    input wire logic port_a_strobe_n_i,
    input wire logic port_b_strobe_n_i,
    output logic port_a_ready_o,
    output logic port_b_ready_o
);
    import pph_pkg::*;

    pph_mode_e mode [2];
    logic [7:0] out_reg [2];
    logic [7:0] in_reg [2];
    logic [7:0] dir [2];
    logic [7:0] mask [2];
    logic [7:0] comp [2];
    logic [7:0] pin [2];
    logic [1:0] int_en, and_sel, high_sel, icw_clr;
    logic [1:0] stb, stb_q, stb_rise, in_stb, in_rise, in_mode;
    logic [1:0] in_full, in_rdy, rearm, out_rdy, rd_sel, rd_end, wr_end;
    logic [1:0] force_cnt [2];
    logic [1:0] eq, eq_q, eq_rise, ev, held, ip, ius, req;
    logic rd_act, rd_q, rd_port_q, wr_act, wr_q, wr_port_q;
    logic m1_act, m1_q, ack, ack_q, ack_start, fetch;
    logic iei_b, sel_a, sel_b, ed_seen, priority_enable_out;
    logic [7:0] opc_cap;

    assign pin[0] = port_a_data_i;
    assign pin[1] = port_b_data_i;
    assign stb = ~{port_b_strobe_n_i, port_a_strobe_n_i};
    assign stb_rise = stb_q & ~stb;
    assign m1_act = ~opcode_fetch_strobe_n_i;
    assign ack = m1_act & ~io_request_strobe_n_i;
    assign ack_start = ack & ~ack_q;
    assign fetch = m1_act & io_request_strobe_n_i & ~rd_n_i;
    assign rd_act = ~chip_sel_n_i & ~io_request_strobe_n_i & ~rd_n_i & ~m1_act & ~ctrl_sel_i;
    assign wr_act = ~chip_sel_n_i & ~io_request_strobe_n_i & rd_n_i & ~m1_act & ~ctrl_sel_i;
    assign rd_sel = rd_act ? (port_sel_i ? 2'b10 : 2'b01) : 2'b00;
    assign rd_end = (rd_q & ~rd_act) ? (rd_port_q ? 2'b10 : 2'b01) : 2'b00;
    assign wr_end = (wr_q & ~wr_act) ? (wr_port_q ? 2'b10 : 2'b01) : 2'b00;
    // Input channel of port A takes port B's strobe when bidirectional
    assign in_stb[0] = (mode[0] == PPH_MODE_BIDIR) ? stb[1] : stb[0];
    assign in_rise[0] = (mode[0] == PPH_MODE_BIDIR) ? stb_rise[1] : stb_rise[0];
    assign in_stb[1] = stb[1];
    assign in_rise[1] = stb_rise[1];
    assign in_mode[0] = (mode[0] == PPH_MODE_IN) || (mode[0] == PPH_MODE_BIDIR);
    assign in_mode[1] = (mode[1] == PPH_MODE_IN);

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            comp[p] = (out_reg[p] & ~dir[p]) | (in_reg[p] & dir[p]);
            eq[p] = (mode[p] == PPH_MODE_BITCTL) &&
                eq_eval((out_reg[p] & ~dir[p]) | (pin[p] & dir[p]),
                        mask[p], and_sel[p], high_sel[p]);
        end
    end
    assign eq_rise = eq & ~eq_q;
    // Strobe-edge and equation events; B also carries A's bidir input event
    assign ev[0] = (stb_rise[0] & (mode[0] != PPH_MODE_BITCTL)) | eq_rise[0];
    assign ev[1] = (stb_rise[1] & ((mode[1] != PPH_MODE_BITCTL) ||
                    (mode[0] == PPH_MODE_BIDIR))) | eq_rise[1];
    assign req = ip & int_en;
    // Port A ranks above B inside the device
    assign iei_b = priority_enable_in_i & ~ius[0] & ~(req[0] & ~ed_seen);
    assign sel_a = priority_enable_in_i & req[0] & ~ius[0];
    assign sel_b = iei_b & req[1] & ~ius[1] & ~sel_a;
    // Pending requests stop blocking the chain from the end of the prefix fetch to the end of the next fetch
    assign priority_enable_out = priority_enable_in_i & ~(|ius) & ~((|req) & ~ed_seen);

    // Bus strobe history
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stb_q <= 2'b00;
            rd_q <= 1'b0;
            rd_port_q <= 1'b0;
            wr_q <= 1'b0;
            wr_port_q <= 1'b0;
            m1_q <= 1'b0;
            ack_q <= 1'b0;
            eq_q <= 2'b00;
        end else begin
            stb_q <= stb;
            rd_q <= rd_act;
            wr_q <= wr_act;
            if (rd_act) begin
                rd_port_q <= port_sel_i;
            end
            if (wr_act) begin
                wr_port_q <= port_sel_i;
            end
            m1_q <= m1_act;
            ack_q <= ack;
            eq_q <= eq;
        end
    end

    // Configuration words
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= '{MODE_RST, MODE_RST};
            dir <= '{DIR_RST, DIR_RST};
            mask <= '{MASK_RST, MASK_RST};
            int_en <= 2'b00;
            and_sel <= 2'b00;
            high_sel <= 2'b00;
        end else if (cfg_wr_i) begin
            unique case (cfg_kind_i)
                PPH_CFG_MODE: begin
                    if (cfg_word_i[3:0] == SET_MODE_TAG && !(cfg_port_i &&
                        cfg_word_i[MODE_MSB:MODE_LSB] == PPH_MODE_BIDIR)) begin
                        mode[cfg_port_i] <= pph_mode_e'(cfg_word_i[MODE_MSB:MODE_LSB]);
                    end
                end
                PPH_CFG_ICW: begin
                    int_en[cfg_port_i] <= cfg_word_i[ICW_EN_BIT];
                    and_sel[cfg_port_i] <= cfg_word_i[ICW_AND_BIT];
                    high_sel[cfg_port_i] <= cfg_word_i[ICW_HIGH_BIT];
                end
                PPH_CFG_DIR: dir[cfg_port_i] <= cfg_word_i;
                PPH_CFG_MASK: mask[cfg_port_i] <= cfg_word_i;
            endcase
        end
    end
    assign icw_clr = (cfg_wr_i && cfg_kind_i == PPH_CFG_ICW && cfg_word_i[ICW_CLR_BIT]) ?
        (cfg_port_i ? 2'b10 : 2'b01) : 2'b00;

    // Data registers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_reg <= '{DATA_RST, DATA_RST};
            in_reg <= '{DATA_RST, DATA_RST};
        end else begin
            if (wr_act) begin
                out_reg[port_sel_i] <= cpu_data_i;
            end
            for (int c = 0; c < 2; c++) begin
                if (in_mode[c] && in_stb[c] && !in_full[c]) begin
                    in_reg[c] <= pin[c];
                end else if (mode[c] == PPH_MODE_BITCTL && !rd_sel[c]) begin
                    in_reg[c] <= pin[c];
                end
            end
        end
    end

    // Input and output handshakes
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_full <= 2'b00;
            in_rdy <= 2'b00;
            rearm <= 2'b00;
            out_rdy <= 2'b00;
            force_cnt <= '{2'd0, 2'd0};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (in_mode[c] && in_rise[c]) begin
                    in_full[c] <= 1'b1;
                end else if (rd_end[c]) begin
                    in_full[c] <= 1'b0;
                end
                if (rd_sel[c] && !rd_q) begin
                    force_cnt[c] <= FORCE_LOW_CYC;
                end else if (force_cnt[c] != 2'd0) begin
                    force_cnt[c] <= force_cnt[c] - 2'd1;
                end
                if (rd_end[c]) begin
                    rearm[c] <= 1'b1;
                end else if (force_cnt[c] == 2'd0 || !in_mode[c]) begin
                    rearm[c] <= 1'b0;
                end
                if (!in_mode[c] || rd_sel[c] || (in_rise[c] && in_mode[c])) begin
                    in_rdy[c] <= 1'b0;
                end else if (rearm[c] && force_cnt[c] == 2'd0) begin
                    in_rdy[c] <= 1'b1;
                end
                if (stb_rise[c]) begin
                    out_rdy[c] <= 1'b0;
                end else if (wr_end[c]) begin
                    out_rdy[c] <= 1'b1;
                end
            end
        end
    end

    // Interrupt request, service and return decoding
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ip <= 2'b00;
            held <= 2'b00;
            ius <= 2'b00;
            opc_cap <= DATA_RST;
            ed_seen <= 1'b0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (icw_clr[p]) begin
                    ip[p] <= 1'b0;
                    held[p] <= 1'b0;
                end else if (m1_act) begin
                    held[p] <= held[p] | ev[p];
                end else if (ev[p] || held[p]) begin
                    ip[p] <= 1'b1;
                    held[p] <= 1'b0;
                end
            end
            if (ack_start && sel_a) begin
                ip[0] <= 1'b0;
                ius[0] <= 1'b1;
            end else if (ack_start && sel_b) begin
                ip[1] <= 1'b0;
                ius[1] <= 1'b1;
            end
            if (fetch) begin
                opc_cap <= cpu_data_i;
            end
            if (m1_q && !m1_act) begin
                ed_seen <= (opc_cap == OPC_PREFIX) && !ack_q;
                if (ed_seen && opc_cap == OPC_RETURN_FROM_INTERRUPT_INSTR_2ND && priority_enable_in_i) begin
                    if (ius[0]) begin
                        ius[0] <= 1'b0;
                    end else begin
                        ius[1] <= 1'b0;
                    end
                end
            end
        end
    end

    // Registered pins
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_data_o <= DATA_RST;
            cpu_data_oe_o <= 1'b0;
            int_n_o <= 1'b1;
            priority_enable_out_o <= 1'b0;
            port_a_data_o <= DATA_RST;
            port_b_data_o <= DATA_RST;
            port_a_data_oe_o <= 8'h00;
            port_b_data_oe_o <= 8'h00;
            port_a_ready_o <= 1'b0;
            port_b_ready_o <= 1'b0;
        end else begin
            cpu_data_oe_o <= (ack && (sel_a || sel_b || ack_q && cpu_data_oe_o)) || rd_act;
            if (ack_start) begin
                cpu_data_o <= sel_a ? vector_a_i : vector_b_i;
            end else if (rd_act) begin
                unique case (mode[port_sel_i])
                    PPH_MODE_OUT: cpu_data_o <= out_reg[port_sel_i];
                    PPH_MODE_BITCTL: cpu_data_o <= comp[port_sel_i];
                    default: cpu_data_o <= in_reg[port_sel_i];
                endcase
            end
            int_n_o <= ~((priority_enable_in_i & req[0] & ~ius[0]) |
                         (iei_b & req[1] & ~ius[1]));
            // Registered enable-out keeps ripple short for a four-device chain
            priority_enable_out_o <= priority_enable_out;
            port_a_data_o <= out_reg[0];
            port_b_data_o <= out_reg[1];
            unique case (mode[0])
                PPH_MODE_OUT: port_a_data_oe_o <= 8'hff;
                PPH_MODE_BIDIR: port_a_data_oe_o <= stb[0] ? 8'hff : 8'h00;
                PPH_MODE_BITCTL: port_a_data_oe_o <= ~dir[0];
                PPH_MODE_IN: port_a_data_oe_o <= 8'h00;
            endcase
            unique case (mode[1])
                PPH_MODE_OUT: port_b_data_oe_o <= 8'hff;
                PPH_MODE_BITCTL: port_b_data_oe_o <= ~dir[1];
                default: port_b_data_oe_o <= 8'h00;
            endcase
            unique case (mode[0])
                PPH_MODE_IN: port_a_ready_o <= in_rdy[0];
                PPH_MODE_BITCTL: port_a_ready_o <= 1'b0;
                default: port_a_ready_o <= out_rdy[0];
            endcase
            if (mode[0] == PPH_MODE_BIDIR) begin
                port_b_ready_o <= in_rdy[0];
            end else begin
                unique case (mode[1])
                    PPH_MODE_IN: port_b_ready_o <= in_rdy[1];
                    PPH_MODE_BITCTL: port_b_ready_o <= 1'b0;
                    default: port_b_ready_o <= out_rdy[1];
                endcase
            end
        end
    end

    sequence s_read_a_start;
        rd_sel[0] && !rd_q;
    endsequence
    sequence s_read_a_done;
        rd_end[0] ##1 (rearm[0] && force_cnt[0] == 2'd0);
    endsequence

    chk_bitctl_ready_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode[0] == PPH_MODE_BITCTL |=> !port_a_ready_o) else $error("A ready high in bit mode");
    chk_strobe_drops_ready: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (in_mode[1] && in_rise[1] && mode[0] != PPH_MODE_BIDIR) |=> !in_rdy[1] ##1 !port_b_ready_o)
        else $error("Ready not dropped after strobe");
    chk_force_low_time: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_read_a_start |=> !in_rdy[0] [*2]) else $error("Ready not forced low on read");
    chk_ready_rearm: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_read_a_done ##0 (in_mode[0] && !rd_sel[0] && !in_rise[0]) |=> in_rdy[0])
        else $error("Ready not restored after read");
    chk_fetch_freeze: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $past(m1_act && !ack_start && icw_clr == 2'b00) |-> ip == $past(ip))
        else $error("Request changed during fetch strobe");
    chk_defer_request: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (held[1] && !m1_act && icw_clr == 2'b00) |=> ip[1])
        else $error("Deferred request lost");
    chk_equation_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode[1] == PPH_MODE_BITCTL && mode[0] != PPH_MODE_BIDIR && eq[1] && eq_q[1] &&
         !ip[1] && !held[1] && icw_clr == 2'b00) |=> !ip[1])
        else $error("Equation requested while already true");
    chk_ack_vector: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ack_start && sel_a) |=> (cpu_data_o == $past(vector_a_i)) && cpu_data_oe_o)
        else $error("Wrong vector on acknowledge");
    chk_service_blocks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ius[0] |=> !priority_enable_out_o) else $error("Enable-out high under service");
    chk_bidir_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode[0] == PPH_MODE_BIDIR && !stb[0]) |=> port_a_data_oe_o == 8'h00)
        else $error("Port A driven with strobe high");

endmodule

//--- src/pph_pkg.sv
package pph_pkg;

    typedef enum logic [1:0] {
        PPH_MODE_OUT    = 2'b00,
        PPH_MODE_IN     = 2'b01,
        PPH_MODE_BIDIR  = 2'b10,
        PPH_MODE_BITCTL = 2'b11
    } pph_mode_e;

    typedef enum logic [1:0] {
        PPH_CFG_MODE = 2'b00,
        PPH_CFG_ICW  = 2'b01,
        PPH_CFG_DIR  = 2'b10,
        PPH_CFG_MASK = 2'b11
    } pph_cfg_e;

    // Mode word fields
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam logic [3:0] SET_MODE_TAG = 4'hf;
    // Interrupt control word fields
    localparam int ICW_EN_BIT = 7;
    localparam int ICW_AND_BIT = 6;
    localparam int ICW_HIGH_BIT = 5;
    localparam int ICW_CLR_BIT = 4;
    // Return-from-interrupt opcode pair
    localparam logic [7:0] OPC_PREFIX = 8'hed;
    localparam logic [7:0] OPC_RETURN_FROM_INTERRUPT_INSTR_2ND = 8'h4d;
    // Forced ready-low time, in half clock periods, rounded up to cycles
    localparam int FORCE_LOW_HALF_PERIODS = 3;
    localparam logic [1:0] FORCE_LOW_CYC = 2'((FORCE_LOW_HALF_PERIODS + 1) / 2);
    // Reset values
    localparam pph_mode_e MODE_RST = PPH_MODE_IN;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Monitored-lines equation of bit control mode
    function automatic logic eq_eval(input logic [7:0] v, input logic [7:0] msk,
                                     input logic and_s, input logic high_s);
        logic [7:0] act;
        act = high_s ? v : ~v;
        if (and_s) begin
            eq_eval = (&(act | msk)) & ~(&msk);
        end else begin
            eq_eval = |(act & ~msk);
        end
    endfunction

endpackage

//--- testbench/pph_peripheral.sv
`timescale 1ns/1ps
module pph_peripheral (
    input wire logic core_clk_i,
    input wire logic [2:0] cmd_i,
    input wire logic hold_b_i,
    input wire logic [7:0] byte_i,
    input wire logic [7:0] a_out_i,
    input wire logic [7:0] a_oe_i,
    input wire logic [7:0] b_out_i,
    input wire logic [7:0] b_oe_i,
    output logic a_stb_n_o,
    output logic b_stb_n_o,
    output logic [7:0] a_pin_o,
    output logic [7:0] b_pin_o,
    output logic [7:0] seen_o
);
    logic [2:0] kind = 3'h0;
    logic [1:0] cnt = 2'h0;
    logic [7:0] a_last = 8'h00;
    logic [7:0] b_last = 8'h00;
    logic a_on;
    logic b_on;
    initial begin
        a_stb_n_o = 1'b1;
        b_stb_n_o = 1'b1;
        seen_o = 8'h00;
    end
    // Kinds: 1 A strobe, byte on A; 2 B strobe, byte on B; 3 B strobe, byte on A; 4 A strobe, take A
    always @(posedge core_clk_i) begin
        if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
            if (cnt == 2'h1) begin
                a_stb_n_o <= 1'b1;
                b_stb_n_o <= 1'b1;
            end
        end else if (cmd_i != 3'h0) begin
            kind <= cmd_i;
            cnt <= 2'h3;
            a_stb_n_o <= !(cmd_i == 3'h1 || cmd_i == 3'h4);
            b_stb_n_o <= !(cmd_i == 3'h2 || cmd_i == 3'h3);
        end
    end
    // Byte only while its kind's strobe is low, gone at the rise; B also while hold_b_i is high
    assign a_on = (kind == 3'h1 && !a_stb_n_o) || (kind == 3'h3 && !b_stb_n_o);
    assign b_on = hold_b_i || (kind == 3'h2 && !b_stb_n_o);
    // Released lines show the inverse of their last level
    assign a_pin_o = (a_oe_i & a_out_i) | (~a_oe_i & (a_on ? byte_i : ~a_last));
    assign b_pin_o = (b_oe_i & b_out_i) | (~b_oe_i & (b_on ? byte_i : ~b_last));
    always @(posedge core_clk_i) begin
        a_last <= a_pin_o;
        b_last <= b_pin_o;
    end
    always @(posedge a_stb_n_o) begin
        seen_o <= a_pin_o;
    end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pph_pkg::*;
    localparam logic [7:0] VEC_A = 8'h10;
    localparam logic [7:0] VEC_B = 8'h12;
    logic core_clk_i = 1'b0, rst_i = 1'b1, chip_sel_n_i = 1'b1, port_sel_i = 1'b0, rd_n_i = 1'b1;
    logic ioreq_n = 1'b1, fetch_n = 1'b1, cfg_wr_i = 1'b0, cfg_port_i = 1'b0, p_hold = 1'b0;
    pph_cfg_e cfg_kind_i = PPH_CFG_MODE;
    logic [7:0] cfg_word_i = 8'h00, cpu_in = 8'h00, p_byte = 8'h00, r;
    logic [2:0] p_cmd = 3'h0;
    logic [7:0] cpu_out, pa_out, pa_oe, pb_out, pb_oe, pa_pin, pb_pin, seen;
    logic cpu_oe, int_n, ie_out, a_stb_n, b_stb_n, a_rdy, b_rdy;
    logic ie_in = 1'b1;
    logic [1:0] s;
    int num_errors = 0, num_checks = 0, cycles = 0;
    pph_parallel_port i_pph_parallel_port (
        .core_clk_i, .rst_i, .chip_sel_n_i, .port_sel_i, .ctrl_sel_i(1'b0), .rd_n_i,
        .io_request_strobe_n_i(ioreq_n), .opcode_fetch_strobe_n_i(fetch_n),
        .cpu_data_i(cpu_in), .cpu_data_o(cpu_out), .cpu_data_oe_o(cpu_oe), .int_n_o(int_n),
        .priority_enable_in_i(ie_in), .priority_enable_out_o(ie_out), .cfg_wr_i, .cfg_port_i,
        .cfg_kind_i, .cfg_word_i, .vector_a_i(VEC_A), .vector_b_i(VEC_B),
        .port_a_data_i(pa_pin), .port_a_data_o(pa_out), .port_a_data_oe_o(pa_oe),
        .port_b_data_i(pb_pin), .port_b_data_o(pb_out), .port_b_data_oe_o(pb_oe),
        .port_a_strobe_n_i(a_stb_n), .port_b_strobe_n_i(b_stb_n), .port_a_ready_o(a_rdy),
        .port_b_ready_o(b_rdy)
    );
    pph_peripheral i_pph_peripheral (
        .core_clk_i, .cmd_i(p_cmd), .hold_b_i(p_hold), .byte_i(p_byte), .a_out_i(pa_out),
        .a_oe_i(pa_oe), .b_out_i(pb_out), .b_oe_i(pb_oe), .a_stb_n_o(a_stb_n),
        .b_stb_n_o(b_stb_n), .a_pin_o(pa_pin), .b_pin_o(pb_pin), .seen_o(seen)
    );
    always #12.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles > 4000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int w);
        sig = w == 0 ? a_rdy : w == 1 ? b_rdy : w == 2 ? int_n : ie_out;
    endfunction
    // Bounded wait for a level on ready A, ready B, interrupt or enable out
    task automatic await(input int w, input logic lvl, input int lim);
        for (int i = 0; i < lim && sig(w) !== lvl; i++) begin
            @(posedge core_clk_i);
            #1;
        end
        chk8({7'h00, sig(w)}, {7'h00, lvl});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic cfg(input logic p, input pph_cfg_e k, input logic [7:0] w);
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_port_i <= p;
        cfg_kind_i <= k;
        cfg_word_i <= w;
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b0;
    endtask
    task automatic cpu(input logic p, input logic rd, input logic [7:0] w);
        @(posedge core_clk_i);
        chip_sel_n_i <= 1'b0;
        ioreq_n <= 1'b0;
        rd_n_i <= !rd;
        port_sel_i <= p;
        cpu_in <= w;
        idle(3);
        r = cpu_out;
        s = {p ? b_rdy : a_rdy, cpu_oe};
        @(posedge core_clk_i);
        chip_sel_n_i <= 1'b1;
        ioreq_n <= 1'b1;
        rd_n_i <= 1'b1;
    endtask
    task automatic fetch(input logic [7:0] op, input logic ack);
        @(posedge core_clk_i);
        fetch_n <= 1'b0;
        rd_n_i <= ack;
        cpu_in <= op;
        // Two cycles for the chain to settle before the request strobe
        repeat (2) @(posedge core_clk_i);
        ioreq_n <= !ack;
        idle(2);
        r = cpu_out;
        s = {int_n, ie_out};
        @(posedge core_clk_i);
        fetch_n <= 1'b1;
        ioreq_n <= 1'b1;
        rd_n_i <= 1'b1;
    endtask
    task automatic strobe(input logic [2:0] k, input logic [7:0] d);
        @(posedge core_clk_i);
        p_cmd <= k;
        p_byte <= d;
        @(posedge core_clk_i);
        p_cmd <= 3'h0;
        idle(6);
    endtask
    task automatic pins(input logic h, input logic [7:0] b);
        @(posedge core_clk_i);
        p_hold <= h;
        p_byte <= b;
    endtask
    task automatic test_input();
        cfg(1'b0, PPH_CFG_ICW, 8'h80);
        chk8({7'h00, a_rdy}, 8'h00);
        cpu(1'b0, 1'b1, 8'h00);
        await(0, 1'b1, 5);
        strobe(3'h1, 8'h5a);
        await(0, 1'b0, 1);
        await(2, 1'b0, 1);
        strobe(3'h1, 8'ha5);
        cpu(1'b0, 1'b1, 8'h00);
        chk8(r, 8'h5a);
        await(0, 1'b1, 5);
        cpu(1'b0, 1'b1, 8'h00);
        chk8({6'h00, s}, 8'h01);
        await(0, 1'b1, 5);
        @(posedge core_clk_i);
        ie_in <= 1'b0;
        idle(2);
        chk8({6'h00, int_n, ie_out}, 8'h02);
        @(posedge core_clk_i);
        ie_in <= 1'b1;
    endtask
    task automatic test_ack();
        cfg(1'b1, PPH_CFG_ICW, 8'h80);
        cpu(1'b1, 1'b1, 8'h00);
        strobe(3'h2, 8'h77);
        fetch(8'h00, 1'b1);
        chk8(r, VEC_A);
        fetch(OPC_PREFIX, 1'b0);
        chk8({7'h00, s[0]}, 8'h00);
        fetch(OPC_RETURN_FROM_INTERRUPT_INSTR_2ND, 1'b0);
        fetch(8'h00, 1'b1);
        chk8(r, VEC_B);
        fetch(OPC_PREFIX, 1'b0);
        fetch(OPC_RETURN_FROM_INTERRUPT_INSTR_2ND, 1'b0);
        await(2, 1'b1, 3);
        cpu(1'b0, 1'b1, 8'h00);
        strobe(3'h1, 8'h3c);
        await(3, 1'b0, 3);
        fetch(OPC_PREFIX, 1'b0);
        fetch(OPC_RETURN_FROM_INTERRUPT_INSTR_2ND, 1'b0);
        chk8({7'h00, s[0]}, 8'h01);
        cfg(1'b0, PPH_CFG_ICW, 8'h90);
        await(2, 1'b1, 3);
    endtask
    task automatic test_bitctl();
        pins(1'b1, 8'h04);
        cfg(1'b1, PPH_CFG_MODE, 8'hcf);
        cfg(1'b1, PPH_CFG_DIR, 8'h0f);
        cfg(1'b1, PPH_CFG_MASK, 8'hfc);
        cfg(1'b1, PPH_CFG_ICW, 8'hb0);
        cpu(1'b1, 1'b0, 8'ha5);
        cpu(1'b1, 1'b1, 8'h00);
        chk8(r, 8'ha4);
        chk8({6'h00, s}, 8'h01);
        chk8({7'h00, int_n}, 8'h01);
        pins(1'b1, 8'h01);
        await(2, 1'b0, 4);
        cfg(1'b1, PPH_CFG_ICW, 8'hb0);
        pins(1'b1, 8'h03);
        idle(4);
        chk8({7'h00, int_n}, 8'h01);
        pins(1'b1, 8'h00);
        cfg(1'b1, PPH_CFG_ICW, 8'hf0);
        pins(1'b1, 8'h01);
        idle(4);
        chk8({7'h00, int_n}, 8'h01);
        @(posedge core_clk_i);
        fetch_n <= 1'b0;
        rd_n_i <= 1'b0;
        cpu_in <= 8'h00;
        p_byte <= 8'h03;
        idle(3);
        chk8({7'h00, int_n}, 8'h01);
        @(posedge core_clk_i);
        fetch_n <= 1'b1;
        rd_n_i <= 1'b1;
        await(2, 1'b0, 4);
        cpu(1'b0, 1'b1, 8'h00);
        await(0, 1'b1, 5);
        cfg(1'b0, PPH_CFG_MODE, 8'hcf);
        idle(1);
        chk8({7'h00, a_rdy}, 8'h00);
        cfg(1'b0, PPH_CFG_MODE, 8'h40);
        cpu(1'b0, 1'b1, 8'h00);
        idle(4);
        chk8({7'h00, a_rdy}, 8'h00);
        cfg(1'b1, PPH_CFG_MODE, 8'h8f);
        pins(1'b1, 8'h0c);
        cpu(1'b1, 1'b1, 8'h00);
        chk8(r, 8'hac);
        cfg(1'b1, PPH_CFG_ICW, 8'h10);
    endtask
    task automatic test_bidir();
        pins(1'b0, 8'h00);
        cfg(1'b1, PPH_CFG_MASK, 8'hff);
        cfg(1'b0, PPH_CFG_ICW, 8'h10);
        cfg(1'b0, PPH_CFG_MODE, 8'h8f);
        cpu(1'b0, 1'b0, 8'h3c);
        await(0, 1'b1, 3);
        chk8(pa_oe, 8'h00);
        strobe(3'h4, 8'h00);
        chk8(seen, 8'h3c);
        await(0, 1'b0, 1);
        cfg(1'b0, PPH_CFG_ICW, 8'h90);
        cfg(1'b1, PPH_CFG_ICW, 8'h90);
        cpu(1'b0, 1'b1, 8'h00);
        await(1, 1'b1, 5);
        strobe(3'h3, 8'hc3);
        await(2, 1'b0, 3);
        cpu(1'b0, 1'b1, 8'h00);
        chk8(r, 8'hc3);
        fetch(8'h00, 1'b1);
        chk8(r, VEC_B);
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        chk8({a_rdy, b_rdy, int_n, ie_out, cpu_oe, 3'h0}, 8'h20);
        chk8(pa_oe | pb_oe, 8'h00);
        test_input();
        test_ack();
        test_bitctl();
        test_bidir();
        stop_test();
    end
endmodule
